// ===== rtl/pxl_pkg.sv
// Package for the crosslink control block: types and constants
package pxl_pkg;

  // Port mode within the switch
  localparam logic PORT_MODE_DOWN = 1'b0;  // Downstream switch port
  localparam logic PORT_MODE_UP   = 1'b1;  // Upstream switch port

  // Lane orientation encodings
  localparam logic ORIENT_DOWN_LANES = 1'b0;  // Acts as upstream component
  localparam logic ORIENT_UP_LANES   = 1'b1;  // Acts as downstream component

  // Reset values
  localparam logic RST_ORIENT       = 1'b0;
  localparam logic RST_XLINK_OFF    = 1'b0;
  localparam logic [1:0] RST_SPEED  = 2'h1;

  // Link speeds
  localparam logic [1:0] SPEED_GEN1 = 2'h1;
  localparam logic [1:0] SPEED_GEN2 = 2'h2;

  // Group count, width of the port-group field, and training seed width
  localparam int GROUP_COUNT = 4;
  localparam int GROUP_W     = 2;
  localparam int SEED_W      = 16;

  // Link state machine, Gray coded along the normal path
  typedef enum logic [2:0] {
    PXL_DETECT   = 3'h0,
    PXL_TRAIN    = 3'h1,
    PXL_LINKUP   = 3'h3,
    PXL_SPEEDCHG = 3'h2,
    PXL_RECOVERY = 3'h6,
    PXL_HOTRST   = 3'h7
  } pxl_state_t;

  // Training outcome reported by the physical layer
  typedef struct packed {
    logic done;         // Training finished this cycle
    logic same_side;    // Partner is same switch-side type
    logic up_lanes;     // Trained role: upstream lanes
    logic hot_reset;    // Received training sets with hot reset bit
    logic partner_gen2; // Partner asks for Gen2
  } pxl_train_t;

  // Higher-layer hot reset requests
  typedef struct packed {
    logic partition;
    logic up_secondary;
    logic dn_secondary;
  } pxl_hrreq_t;

  // Port group of a port number: n modulo 4
  function automatic logic [GROUP_W-1:0] pxl_group(input logic [3:0] port_num);
    pxl_group = port_num[GROUP_W-1:0];
  endfunction : pxl_group

endpackage : pxl_pkg

// ===== rtl/pxl_crosslink_ctrl.sv
// Crosslink control for one switch port: training gate, orientation, speed, hot reset
//
// Summary of operation
// - Train with same-type partner, down or up
// - Training decides which side has which lanes
// - Report current lane orientation per port
// - Same group crosslink needs differing seeds
// - Upstream crosslink without initiate stays Gen1
// - Initiate bit makes upstream port start Gen2
// - Crosslink on after reset; off bit blocks
// - No dynamic width change while crosslinked
// - Down-mode crosslink enters hot reset on TS
// - Received hot reset keeps config, other ports
// - Down-mode, down-lane port: directed hot reset via recovery
// - Up-lane port has no internal hot reset path
`timescale 1ns/1ns
`default_nettype none

module pxl_crosslink_ctrl
  import pxl_pkg::*;
(
  input  wire  logic              mclk,                            // Core clock, 20 MHz
  input  wire  logic              arst_n,                          // Async reset, active low
  input  wire  logic              port_mode,                       // 0 downstream, 1 upstream switch port
  input  wire  logic [3:0]        port_num,                        // This port's number
  input  wire  logic [3:0]        partner_port_num,                // Partner port number when on-chip
  input  wire  logic              partner_on_chip,                 // Partner is a port of this device
  input  wire  logic [SEED_W-1:0] phy_pattern_seed_reg,            // Own training seed
  input  wire  logic [SEED_W-1:0] partner_seed,                    // Partner training seed
  input  wire  logic              crosslink_off_bit,               // Disable crosslink forming
  input  wire  logic              crosslink_speed_change_initiate, // Upstream port starts Gen2
  input  wire  pxl_train_t        train,                           // Physical layer training result
  input  wire  pxl_hrreq_t        hr_req,                          // Higher-layer hot reset requests
  input  wire  logic              width_change_req,                // Dynamic width reconfig request
  input  wire  logic              speed_change_done,               // Speed change finished
  input  wire  logic              hot_reset_done,                  // Hot reset sequence finished
  input  wire  logic              link_down,                       // Physical link lost
  output logic                    lane_orientation_status,         // 1 upstream lanes, 0 downstream lanes
  output logic                    crosslinked,                     // Link is up as a crosslink
  output logic                    link_up,                         // Link is up
  output logic                    crosslink_refused,               // Last training refused a crosslink
  output logic                    speed_change_start,              // Pulse: start change to Gen2
  output logic [1:0]              link_speed,                      // Current speed
  output logic                    width_change_grant,              // Width reconfig allowed
  output logic                    enter_recovery,                  // Level: PHY in recovery
  output logic                    hot_reset_active,                // Level: PHY in hot reset
  output logic                    cfg_reset_block                  // Keep config regs during hot reset
);

  pxl_state_t state;
  pxl_state_t next_state;

  // Same-group crosslink is only legal with differing seeds
  wire same_group   = partner_on_chip && (pxl_group(port_num) == pxl_group(partner_port_num));
  wire seeds_differ = (phy_pattern_seed_reg != partner_seed);
  wire seed_ok      = !same_group || seeds_differ;
  // Same-type partner allowed unless disabled or seeds clash
  wire xl_allowed   = !crosslink_off_bit && seed_ok;
  wire train_ok     = train.done && (!train.same_side || xl_allowed);
  wire train_refuse = train.done && train.same_side && !xl_allowed;

  // On a crosslink, Gen2 only started by the upstream port with initiate set;
  // without it neither side moves and the link stays at Gen1
  wire xl_up        = crosslinked && (port_mode == PORT_MODE_UP);
  wire want_gen2    = xl_up ? crosslink_speed_change_initiate
                            : (!crosslinked && train.partner_gen2);

  // Directed hot reset only for a downstream-mode port on downstream lanes
  wire hr_any       = hr_req.partition || hr_req.up_secondary || hr_req.dn_secondary;
  wire hr_directed  = hr_any && (port_mode == PORT_MODE_DOWN)
                      && (lane_orientation_status == ORIENT_DOWN_LANES);
  // Received hot reset honoured with either lane orientation
  wire hr_received  = train.hot_reset && (port_mode == PORT_MODE_DOWN);

  // Next-state logic
  always_comb begin
    next_state = state;
    case (state)
      PXL_DETECT: begin
        next_state = PXL_TRAIN;
      end
      PXL_TRAIN: begin
        if (train_ok) begin
          next_state = PXL_LINKUP;
        end
      end
      PXL_LINKUP: begin
        if (link_down) begin
          next_state = PXL_DETECT;
        end else if (hr_received) begin
          next_state = PXL_HOTRST;
        end else if (hr_directed) begin
          next_state = PXL_RECOVERY;
        end else if (want_gen2 && (link_speed == SPEED_GEN1)) begin
          next_state = PXL_SPEEDCHG;
        end
      end
      PXL_SPEEDCHG: begin
        if (link_down) begin
          next_state = PXL_DETECT;
        end else if (speed_change_done) begin
          next_state = PXL_LINKUP;
        end
      end
      PXL_RECOVERY: begin
        next_state = PXL_HOTRST;
      end
      PXL_HOTRST: begin
        if (hot_reset_done) begin
          next_state = PXL_DETECT;
        end
      end
      default: begin
        next_state = PXL_DETECT;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= PXL_DETECT;
    end else begin
      state <= next_state;
    end
  end

  // Orientation latched only when training completes, held otherwise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lane_orientation_status <= RST_ORIENT;
    end else if (state == PXL_TRAIN && train_ok) begin
      lane_orientation_status <= train.up_lanes;
    end
  end

  // Crosslink and link status
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      crosslinked       <= 1'b0;
      link_up           <= 1'b0;
      crosslink_refused <= 1'b0;
    end else begin
      if (state == PXL_TRAIN && train_ok) begin
        crosslinked <= train.same_side;
      end else if (next_state == PXL_DETECT) begin
        crosslinked <= 1'b0;
      end
      link_up <= (next_state == PXL_LINKUP) || (next_state == PXL_SPEEDCHG);
      if (state == PXL_TRAIN && train.done) begin
        crosslink_refused <= train_refuse;
      end
    end
  end

  // Speed tracking; a start pulse marks entry to the speed change
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link_speed         <= RST_SPEED;
      speed_change_start <= 1'b0;
    end else begin
      speed_change_start <= (state == PXL_LINKUP) && (next_state == PXL_SPEEDCHG);
      if (next_state == PXL_DETECT) begin
        link_speed <= SPEED_GEN1;
      end else if (state == PXL_SPEEDCHG && speed_change_done) begin
        link_speed <= SPEED_GEN2;
      end
    end
  end

  // Width change never granted on a crosslink
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      width_change_grant <= 1'b0;
    end else begin
      width_change_grant <= width_change_req && link_up && !crosslinked;
    end
  end

  // Hot reset indications; config regs spared on a received crosslink hot reset so other ports stay untouched
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      enter_recovery   <= 1'b0;
      hot_reset_active <= 1'b0;
      cfg_reset_block  <= 1'b0;
    end else begin
      enter_recovery   <= (next_state == PXL_RECOVERY);
      hot_reset_active <= (next_state == PXL_HOTRST);
      if (state == PXL_LINKUP && hr_received && crosslinked) begin
        cfg_reset_block <= 1'b1;
      end else if (next_state != PXL_HOTRST) begin
        cfg_reset_block <= 1'b0;
      end
    end
  end

endmodule : pxl_crosslink_ctrl

`default_nettype wire

// ===== bench/pxl_partner.sv
// Link partner model: training outcome and received hot reset
`timescale 1ns/1ns
`default_nettype none
module pxl_partner
  import pxl_pkg::*;
(
  input  wire logic              mclk,             // Core clock
  output var  pxl_train_t        train,            // Training outcome seen by the port
  output var  logic [SEED_W-1:0] partner_seed,     // Partner seed
  output var  logic [3:0]        partner_port_num  // Partner port number
);
  // Port 4 shares group 0 with port 0 on purpose, so seeds decide
  initial begin
    train = '0;
    partner_seed = 16'h5A5A;
    partner_port_num = 4'h4;
  end
  // One done pulse; partner takes the opposite lane role
  task automatic link(input logic same, input logic up_lanes, input logic gen2);
    repeat (3) @(posedge mclk);
    train <= '{1'b1, same, up_lanes, 1'b0, gen2};
    @(posedge mclk);
    train.done <= 1'b0;
  endtask : link
  // Only a down-lane partner starts hot reset across the link
  task automatic hot(input logic on);
    @(posedge mclk);
    train.hot_reset <= on;
  endtask : hot
endmodule : pxl_partner
`default_nettype wire

// ===== bench/pxl_crosslink_ctrl_chk.sv
// Assertion checker for the crosslink control block
`timescale 1ns/1ns
`default_nettype none
module pxl_crosslink_chk
  import pxl_pkg::*;
(
  input wire logic       mclk, arst_n, port_mode, link_down,            // Clock, reset, mode
  input wire pxl_train_t train,                                         // Training outcome
  input wire logic       crosslink_off_bit, crosslink_speed_change_initiate, width_change_req,
  input wire logic       lane_orientation_status, crosslinked, link_up, speed_change_start,
  input wire logic       width_change_grant, enter_recovery, hot_reset_active, cfg_reset_block
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  orient_take_a: assert property ($rose(link_up) |-> lane_orientation_status == $past(train.up_lanes))
    else $error("orientation not taken");
  orient_hold_a: assert property (!$rose(link_up) |-> $stable(lane_orientation_status))
    else $error("orientation moved");
  off_block_a: assert property ($rose(crosslinked) |-> !$past(crosslink_off_bit))
    else $error("crosslink despite off bit");
  width_gate_a: assert property (width_change_grant |-> $past(width_change_req && link_up && !crosslinked))
    else $error("width grant wrong");
  gen2_start_a: assert property ($rose(crosslinked) && port_mode && crosslink_speed_change_initiate
    |-> ##[1:2] speed_change_start)
    else $error("no speed change start");
  rx_hot_a: assert property (link_up && crosslinked && !port_mode && train.hot_reset && !link_down
    && !hot_reset_active && !enter_recovery |=> hot_reset_active)
    else $error("received hot reset missed");
  cfg_keep_a: assert property ($rose(hot_reset_active) && $past(crosslinked && train.hot_reset)
    |-> cfg_reset_block)
    else $error("config not kept");
  dir_recov_a: assert property ($rose(hot_reset_active) && !$past(train.hot_reset) |-> $past(enter_recovery))
    else $error("hot reset skipped recovery");
  uplane_none_a: assert property (enter_recovery |-> !lane_orientation_status && !port_mode)
    else $error("up-lane port directed");
endmodule : pxl_crosslink_chk
bind pxl_crosslink_ctrl pxl_crosslink_chk chk (.mclk, .arst_n, .port_mode, .link_down, .train,
  .crosslink_off_bit, .crosslink_speed_change_initiate, .width_change_req, .lane_orientation_status,
  .crosslinked, .link_up, .speed_change_start, .width_change_grant, .enter_recovery,
  .hot_reset_active, .cfg_reset_block);
`default_nettype wire

// ===== bench/pxl_crosslink_ctrl_test.sv
// Testbench for the crosslink control block
`timescale 1ns/1ns
`default_nettype none
module pxl_crosslink_ctrl_test;
  import pxl_pkg::*;
  logic mclk, arst_n, port_mode, partner_on_chip, crosslink_off_bit, crosslink_speed_change_initiate;
  logic width_change_req, speed_change_done, hot_reset_done, link_down;
  logic lane_orientation_status, crosslinked, link_up, crosslink_refused, speed_change_start;
  logic width_change_grant, enter_recovery, hot_reset_active, cfg_reset_block;
  logic [3:0] port_num, partner_port_num;
  logic [SEED_W-1:0] phy_pattern_seed_reg, partner_seed;
  logic [1:0] link_speed;
  logic [1:0] starts = 2'h0;
  pxl_train_t train;
  pxl_hrreq_t hr_req;
  int n_errors = 0;
  int check_count = 0;
  pxl_partner lp (.mclk, .train, .partner_seed, .partner_port_num);
  pxl_crosslink_ctrl DUT (.mclk, .arst_n, .port_mode, .port_num, .partner_port_num, .partner_on_chip,
    .phy_pattern_seed_reg, .partner_seed, .crosslink_off_bit, .crosslink_speed_change_initiate, .train,
    .hr_req, .width_change_req, .speed_change_done, .hot_reset_done, .link_down, .lane_orientation_status,
    .crosslinked, .link_up, .crosslink_refused, .speed_change_start, .link_speed, .width_change_grant,
    .enter_recovery, .hot_reset_active, .cfg_reset_block);
  // Counted at negedge so a one-cycle pulse is never lost
  always @(negedge mclk) if (speed_change_start === 1'b1) starts <= starts + 2'h1;
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic hr_end;
    @(posedge mclk) hot_reset_done <= 1'b1;
    @(posedge mclk) hot_reset_done <= 1'b0;
  endtask : hr_end
  task automatic final_report;
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    final_report;
  end
  initial begin
    {arst_n, port_mode, crosslink_off_bit, crosslink_speed_change_initiate, width_change_req} = '0;
    {speed_change_done, hot_reset_done, link_down, hr_req, port_num} = '0;
    partner_on_chip = 1'b1;
    phy_pattern_seed_reg = 16'h5A5A;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    lp.link(1'b1, 1'b1, 1'b0); cyc(1);
    chk("same seed", 2, {crosslink_refused, crosslinked});
    @(posedge mclk) phy_pattern_seed_reg <= 16'h1234;
    lp.link(1'b1, 1'b1, 1'b0); cyc(1);
    chk("crosslink", 3, {crosslinked, lane_orientation_status});
    @(posedge mclk) {width_change_req, hr_req} <= 4'hC;
    cyc(4);
    chk("grant", 0, width_change_grant);
    chk("directed", 0, hot_reset_active);
    @(posedge mclk) hr_req <= '0;
    lp.hot(1'b1); cyc(2);
    chk("received", 3, {hot_reset_active, cfg_reset_block});
    lp.hot(1'b0); hr_end; cyc(1);
    chk("hold", 2, {lane_orientation_status, link_up});
    // Every directed hot reset kind on a down-lane crosslink
    for (int i = 0; i < 3; i++) begin
      lp.link(1'b1, 1'b0, 1'b0); cyc(1);
      chk("down lanes", 0, lane_orientation_status);
      @(posedge mclk) hr_req <= 3'h1 << i;
      cyc(2);
      chk("recovery", 1, enter_recovery);
      cyc(1);
      chk("hot reset", 1, hot_reset_active);
      @(posedge mclk) hr_req <= '0;
      hr_end;
    end
    @(posedge mclk) port_mode <= 1'b1;
    lp.link(1'b1, 1'b1, 1'b1); cyc(6);
    chk("no start", 0, starts);
    chk("gen1", 1, link_speed);
    @(posedge mclk) {link_down, crosslink_speed_change_initiate} <= 2'h3;
    @(posedge mclk) link_down <= 1'b0;
    lp.link(1'b1, 1'b0, 1'b0); cyc(3);
    chk("start", 1, starts);
    @(posedge mclk) speed_change_done <= 1'b1;
    @(posedge mclk) speed_change_done <= 1'b0;
    cyc(1);
    chk("gen2", 2, link_speed);
    @(posedge mclk) {link_down, crosslink_off_bit} <= 2'h3;
    @(posedge mclk) link_down <= 1'b0;
    lp.link(1'b1, 1'b1, 1'b0); cyc(1);
    chk("off bit", 2, {crosslink_refused, crosslinked});
    lp.link(1'b0, 1'b1, 1'b0); cyc(2);
    chk("grant", 1, width_change_grant);
    final_report;
  end
endmodule : pxl_crosslink_ctrl_test
`default_nettype wire
